// [rtl/srs_pkg.sv]
package srs_pkg;

  // clock and control tick
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_PERIOD_NS = 1000000;
  localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // field widths (frequency in 0.1 Hz, time in 0.1 s, scale in 1 %)
  localparam int unsigned FREQ_W = 12;
  localparam int unsigned TIME_W = 13;
  localparam int unsigned SCALE_W = 10;
  localparam int unsigned FUNC_W = 5;
  localparam int unsigned AOUT_W = 16;
  localparam int unsigned FRAC_W = 16;
  localparam int unsigned DEN_W = 20;
  localparam int unsigned NUM_DIN = 4;
  localparam int unsigned SYNC_W = 10;

  // tenths of a second to control ticks of 1 ms
  localparam logic [DEN_W-1:0] TIME_TO_TICKS = 20'h00064;
  localparam logic [25:0] SCALE_DIVISOR = 26'h0000064;
  localparam logic [AOUT_W-1:0] AOUT_FULL = 16'hFFFF;

  // limits
  localparam logic [FREQ_W-1:0] INT_FREQ_MAX = 12'hFA0;
  localparam logic [TIME_W-1:0] TIME_MAX = 13'h1770;
  localparam logic [SCALE_W-1:0] SCALE_MAX = 10'h320;

  // speed reference source options
  localparam logic [3:0] SRC_INTERNAL = 4'h1;
  localparam logic [3:0] SRC_PRESET_0_3 = 4'h4;

  // digital input function codes
  localparam logic [FUNC_W-1:0] FN_PRESET = 5'h04;
  localparam logic [FUNC_W-1:0] FN_RAMP2 = 5'h05;
  localparam logic [FUNC_W-1:0] FN_JOG = 5'h02;
  localparam logic [FUNC_W-1:0] FN_POT_RAISE = 5'h10;
  localparam logic [FUNC_W-1:0] FN_POT_LOWER = 5'h11;

  // register byte offsets
  localparam logic [7:0] OFS_SOURCE = 8'h00;
  localparam logic [7:0] OFS_DIN_FUNC = 8'h04;
  localparam logic [7:0] OFS_MAX_FREQ = 8'h08;
  localparam logic [7:0] OFS_ACCEL1 = 8'h0C;
  localparam logic [7:0] OFS_DECEL1 = 8'h10;
  localparam logic [7:0] OFS_ACCEL2 = 8'h14;
  localparam logic [7:0] OFS_DECEL2 = 8'h18;
  localparam logic [7:0] OFS_INT_FREQ = 8'h1C;
  localparam logic [7:0] OFS_JOG_FREQ = 8'h20;
  localparam logic [7:0] OFS_JOG_RAMP = 8'h24;
  localparam logic [7:0] OFS_AOUT_SCALE = 8'h28;
  localparam logic [7:0] OFS_AOUT_SOURCE = 8'h2C;
  localparam logic [7:0] OFS_PRESET0 = 8'h30;
  localparam logic [7:0] OFS_PRESET7 = 8'h4C;
  localparam logic [7:0] OFS_STATUS = 8'h50;
  localparam logic [7:0] OFS_AOUT = 8'h54;
  localparam logic [7:0] OFS_LIVE_FREQ = 8'h58;

  // reset values
  localparam logic [3:0] RST_SOURCE = 4'h0;
  localparam logic [FREQ_W-1:0] RST_MAX_FREQ = 12'h258;
  localparam logic [TIME_W-1:0] RST_ACCEL1 = 13'h0064;
  localparam logic [TIME_W-1:0] RST_DECEL1 = 13'h0064;
  localparam logic [TIME_W-1:0] RST_ACCEL2 = 13'h00C8;
  localparam logic [TIME_W-1:0] RST_DECEL2 = 13'h00C8;
  localparam logic [FREQ_W-1:0] RST_INT_FREQ = 12'h258;
  localparam logic [FREQ_W-1:0] RST_JOG_FREQ = 12'h064;
  localparam logic [TIME_W-1:0] RST_JOG_RAMP = 13'h0064;
  localparam logic [SCALE_W-1:0] RST_AOUT_SCALE = 10'h064;
  localparam logic [FREQ_W-1:0] RST_PRESET [8] = '{
    12'h000, 12'h032, 12'h064, 12'h0C8, 12'h12C, 12'h190, 12'h1F4, 12'h258
  };

  // sync bit positions
  localparam int unsigned SB_KEY_UP = 4;
  localparam int unsigned SB_KEY_DOWN = 5;
  localparam int unsigned SB_KEY_ENTER = 6;
  localparam int unsigned SB_KEY_ESC = 7;
  localparam int unsigned SB_PROG_MODE = 8;
  localparam int unsigned SB_JOG = 9;

endpackage : srs_pkg

// [rtl/srs_sync.sv]
`timescale 1ns/10ps
module srs_sync (
  input  wire logic                       ref_clk,
  input  wire logic                       sys_rst,
  input  wire logic [srs_pkg::SYNC_W-1:0] async_in,
  output logic      [srs_pkg::SYNC_W-1:0] sync_out
);
  import srs_pkg::*;

  logic [SYNC_W-1:0] stage1;

  // first stage feeds only the second stage
  for (genvar i = 0; i < SYNC_W; i++) begin : g_bit
    always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
        stage1[i]   <= 1'b0;
        sync_out[i] <= 1'b0;
      end else begin
        stage1[i]   <= async_in[i];
        sync_out[i] <= stage1[i];
      end
    end
  end

endmodule : srs_sync

// [rtl/srs_ramp.sv]
`timescale 1ns/10ps
module srs_ramp (
  input  wire logic                       ref_clk,
  input  wire logic                       sys_rst,
  input  wire logic                       tick,
  input  wire logic [srs_pkg::FREQ_W-1:0] target,
  input  wire logic [srs_pkg::FREQ_W-1:0] max_freq,
  input  wire logic [srs_pkg::TIME_W-1:0] rise_time,
  input  wire logic [srs_pkg::TIME_W-1:0] fall_time,
  output logic      [srs_pkg::FREQ_W-1:0] freq
);
  import srs_pkg::*;

  localparam int unsigned POS_W = FREQ_W + FRAC_W;

  logic [POS_W-1:0] pos;
  logic [POS_W-1:0] rise_step;
  logic [POS_W-1:0] fall_step;
  logic [POS_W-1:0] num;
  logic [DEN_W:0]   rem;
  logic [DEN_W-1:0] den;
  logic [4:0]       cnt;
  logic             sel_fall;
  logic [DEN_W:0]   rem_sh;
  logic [POS_W-1:0] tgt_fx;
  logic [POS_W-1:0] max_fx;

  assign rem_sh = {rem[DEN_W-1:0], num[POS_W-1]};
  assign tgt_fx = {target, {FRAC_W{1'b0}}};
  assign max_fx = {max_freq, {FRAC_W{1'b0}}};
  assign freq   = pos[POS_W-1:FRAC_W];

  // serial divider: step = max_freq / ramp time per tick, rise and fall in turn
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      num       <= '0;
      rem       <= '0;
      den       <= '0;
      cnt       <= '0;
      sel_fall  <= 1'b0;
      rise_step <= '0;
      fall_step <= '0;
    end else if (cnt == 5'h00) begin
      num <= max_fx;
      rem <= '0;
      den <= {7'h00, (sel_fall ? fall_time : rise_time)} * TIME_TO_TICKS;
      cnt <= 5'h01;
    end else if (cnt <= 5'(POS_W)) begin
      if (rem_sh >= {1'b0, den}) begin
        rem <= rem_sh - {1'b0, den};
        num <= {num[POS_W-2:0], 1'b1};
      end else begin
        rem <= rem_sh;
        num <= {num[POS_W-2:0], 1'b0};
      end
      cnt <= cnt + 5'h01;
    end else begin
      // zero time means jump in one tick
      if (sel_fall) begin
        fall_step <= (den == '0) ? max_fx : num;
      end else begin
        rise_step <= (den == '0) ? max_fx : num;
      end
      sel_fall <= ~sel_fall;
      cnt      <= 5'h00;
    end
  end

  // fixed step per tick, landing exactly on the target
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pos <= '0;
    end else if (tick) begin
      if (pos < tgt_fx) begin
        pos <= (tgt_fx - pos <= rise_step) ? tgt_fx : pos + rise_step;
      end else if (pos > tgt_fx) begin
        pos <= (pos - tgt_fx <= fall_step) ? tgt_fx : pos - fall_step;
      end
    end
  end

endmodule : srs_ramp

// [rtl/srs_top.sv]
// Notes on behaviour
// - preset-function input selects stored preset frequency
// - active preset input overrides all other sources
// - inputs one-three index presets; bit1 picks ramp2
// - preset 0 only under preset source option
// - ramp2 selector input forces ramp set two unless jog drives the command
// - accel time two sets non-jog rise rate
// - decel time two sets non-jog fall rate
// - internal source option uses internal frequency
// - program-mode up/down keys change frequency immediately
// - enter saves value; escape ramps back
// - pot raise/lower inputs use internal frequency
// - jog drives jog frequency, limited to maximum
// - jog uses jog ramp time
// - analog full scale times high-scale percentage
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/10ps
module srs_top #(
  parameter int unsigned TICK_CYCLES = srs_pkg::TICK_CYCLES
) (
  input  wire logic                        ref_clk,
  input  wire logic                        sys_rst,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic [srs_pkg::NUM_DIN-1:0] digital_in,
  input  wire logic                        key_up,
  input  wire logic                        key_down,
  input  wire logic                        key_enter,
  input  wire logic                        key_esc,
  input  wire logic                        program_mode,
  input  wire logic                        jog_cmd,
  input  wire logic [srs_pkg::FREQ_W-1:0]  ext_freq_ref,
  input  wire logic [srs_pkg::AOUT_W-1:0]  analog_raw,
  output logic      [srs_pkg::FREQ_W-1:0]  freq_cmd,
  output logic      [srs_pkg::FREQ_W-1:0]  out_freq,
  output logic      [srs_pkg::AOUT_W-1:0]  analog_out,
  output logic                             nv_store
);
  import srs_pkg::*;

  // configuration
  logic [3:0]         speed_ref_source;
  logic [FUNC_W-1:0]  din_func [NUM_DIN];
  logic [FREQ_W-1:0]  max_freq_limit;
  logic [TIME_W-1:0]  accel_time_set1;
  logic [TIME_W-1:0]  decel_time_set1;
  logic [TIME_W-1:0]  accel_time_set2;
  logic [TIME_W-1:0]  decel_time_set2;
  logic [FREQ_W-1:0]  internal_freq_value;
  logic [FREQ_W-1:0]  jog_freq_value;
  logic [TIME_W-1:0]  jog_ramp_time;
  logic [SCALE_W-1:0] analog_out_scale;
  logic [3:0]         analog_out_source;
  logic [FREQ_W-1:0]  preset_freq [8];

  // state
  logic [FREQ_W-1:0]  live_freq;
  logic [SYNC_W-1:0]  sync_bits;
  logic [SYNC_W-1:0]  prev_bits;
  logic [31:0]        tick_cnt;
  logic               tick;
  logic               ramp_out_sel;

  // decode
  logic               apb_write;
  logic               apb_access;
  logic               addr_ok;
  logic [NUM_DIN-1:0] din_on;
  logic [NUM_DIN-1:0] fn_preset;
  logic [NUM_DIN-1:0] fn_ramp2;
  logic [NUM_DIN-1:0] fn_jog;
  logic [NUM_DIN-1:0] fn_raise;
  logic [NUM_DIN-1:0] fn_lower;
  logic [2:0]         preset_idx;
  logic               preset_active;
  logic               pot_mode;
  logic               jog_active;
  logic               ramp2_sel;
  logic [FREQ_W-1:0]  next_freq_cmd;
  logic [TIME_W-1:0]  rise_time;
  logic [TIME_W-1:0]  fall_time;
  logic [FREQ_W-1:0]  ramp_freq;
  logic [25:0]        scaled;
  logic [31:0]        rd_mux;
  logic               up_edge;
  logic               down_edge;
  logic               enter_edge;
  logic               esc_edge;

  srs_sync u_sync (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .async_in ({jog_cmd, program_mode, key_esc, key_enter, key_down, key_up, digital_in}),
    .sync_out (sync_bits)
  );

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prev_bits <= '0;
    end else begin
      prev_bits <= sync_bits;
    end
  end

  assign din_on     = sync_bits[NUM_DIN-1:0];
  assign up_edge    = sync_bits[SB_KEY_UP] & ~prev_bits[SB_KEY_UP];
  assign down_edge  = sync_bits[SB_KEY_DOWN] & ~prev_bits[SB_KEY_DOWN];
  assign enter_edge = sync_bits[SB_KEY_ENTER] & ~prev_bits[SB_KEY_ENTER];
  assign esc_edge   = sync_bits[SB_KEY_ESC] & ~prev_bits[SB_KEY_ESC];

  // per-input function decode
  for (genvar i = 0; i < NUM_DIN; i++) begin : g_din
    assign fn_preset[i] = (din_func[i] == FN_PRESET);
    assign fn_ramp2[i]  = (din_func[i] == FN_RAMP2);
    assign fn_jog[i]    = (din_func[i] == FN_JOG);
    assign fn_raise[i]  = (din_func[i] == FN_POT_RAISE);
    assign fn_lower[i]  = (din_func[i] == FN_POT_LOWER);
  end

  // only inputs one to three carry preset index bits
  assign preset_idx    = din_on[2:0] & fn_preset[2:0];
  assign preset_active = |preset_idx;
  assign pot_mode      = |(fn_raise | fn_lower);
  assign jog_active    = sync_bits[SB_JOG] | |(fn_jog & din_on);
  assign ramp2_sel     = |(fn_ramp2 & din_on);

  // frequency command source priority
  always_comb begin
    if (preset_active) begin
      next_freq_cmd = preset_freq[preset_idx];
    end else if (speed_ref_source == SRC_PRESET_0_3) begin
      next_freq_cmd = preset_freq[0];
    end else if (jog_active) begin
      next_freq_cmd = jog_freq_value;
    end else if (speed_ref_source == SRC_INTERNAL || pot_mode) begin
      next_freq_cmd = live_freq;
    end else begin
      next_freq_cmd = ext_freq_ref;
    end
    if (next_freq_cmd > max_freq_limit) begin
      next_freq_cmd = max_freq_limit;
    end
  end

  // ramp set choice; jog ramp applies only when jog actually drives the command
  always_comb begin
    if (jog_active && !preset_active && speed_ref_source != SRC_PRESET_0_3) begin
      rise_time = jog_ramp_time;
      fall_time = jog_ramp_time;
    end else if (ramp2_sel || ((preset_active || speed_ref_source == SRC_PRESET_0_3)
                 && preset_idx[1])) begin
      rise_time = accel_time_set2;
      fall_time = decel_time_set2;
    end else begin
      rise_time = accel_time_set1;
      fall_time = decel_time_set1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      freq_cmd <= '0;
    end else begin
      freq_cmd <= next_freq_cmd;
    end
  end

  // control tick
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else if (tick_cnt >= TICK_CYCLES - 1) begin
      tick_cnt <= '0;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
      tick     <= 1'b0;
    end
  end

  srs_ramp u_ramp (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .tick      (tick),
    .target    (freq_cmd),
    .max_freq  (max_freq_limit),
    .rise_time (rise_time),
    .fall_time (fall_time),
    .freq      (ramp_freq)
  );

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      out_freq <= '0;
    end else begin
      out_freq <= ramp_freq;
    end
  end

  // live internal frequency: keys act at once, pot inputs step once per control tick, escape restores
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      live_freq <= RST_INT_FREQ;
    end else if (apb_write && paddr == OFS_INT_FREQ) begin
      live_freq <= pwdata[FREQ_W-1:0];
    end else if (esc_edge) begin
      live_freq <= internal_freq_value;
    end else if (((program_mode_s() && up_edge) || (tick && |(fn_raise & din_on)))
                 && live_freq < INT_FREQ_MAX) begin
      live_freq <= live_freq + 12'h001;
    end else if (((program_mode_s() && down_edge) || (tick && |(fn_lower & din_on)))
                 && live_freq != '0) begin
      live_freq <= live_freq - 12'h001;
    end
  end

  function automatic logic program_mode_s();
    return sync_bits[SB_PROG_MODE];
  endfunction : program_mode_s

  // enter commits the live value to the stored one
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      nv_store <= 1'b0;
    end else begin
      nv_store <= enter_edge;
    end
  end

  // analog output scaled by percentage, saturating at full span
  assign scaled = {10'h000, analog_raw} * {16'h0000, analog_out_scale} / SCALE_DIVISOR;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      analog_out <= '0;
    end else if (scaled > {10'h000, AOUT_FULL}) begin
      analog_out <= AOUT_FULL;
    end else begin
      analog_out <= scaled[AOUT_W-1:0];
    end
  end

  // APB slave: one wait state, write on the completing edge
  assign apb_access = psel & penable;
  assign apb_write  = apb_access & pready & pwrite;
  assign addr_ok    = (paddr[1:0] == 2'b00) && (paddr <= OFS_LIVE_FREQ);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      speed_ref_source  <= RST_SOURCE;
      max_freq_limit    <= RST_MAX_FREQ;
      accel_time_set1   <= RST_ACCEL1;
      decel_time_set1   <= RST_DECEL1;
      accel_time_set2   <= RST_ACCEL2;
      decel_time_set2   <= RST_DECEL2;
      jog_freq_value    <= RST_JOG_FREQ;
      jog_ramp_time     <= RST_JOG_RAMP;
      analog_out_scale  <= RST_AOUT_SCALE;
      analog_out_source <= 4'h0;
      for (int k = 0; k < NUM_DIN; k++) begin
        din_func[k] <= '0;
      end
      for (int k = 0; k < 8; k++) begin
        preset_freq[k] <= RST_PRESET[k];
      end
    end else if (apb_write) begin
      unique case (paddr)
        OFS_SOURCE:      speed_ref_source <= pwdata[3:0];
        OFS_DIN_FUNC: begin
          for (int k = 0; k < NUM_DIN; k++) begin
            din_func[k] <= pwdata[8*k +: FUNC_W];
          end
        end
        OFS_MAX_FREQ:    max_freq_limit <= pwdata[FREQ_W-1:0];
        OFS_ACCEL1:      accel_time_set1 <= pwdata[TIME_W-1:0];
        OFS_DECEL1:      decel_time_set1 <= pwdata[TIME_W-1:0];
        OFS_ACCEL2:      accel_time_set2 <= pwdata[TIME_W-1:0];
        OFS_DECEL2:      decel_time_set2 <= pwdata[TIME_W-1:0];
        OFS_JOG_FREQ:    jog_freq_value <= pwdata[FREQ_W-1:0];
        OFS_JOG_RAMP:    jog_ramp_time <= pwdata[TIME_W-1:0];
        OFS_AOUT_SCALE:  analog_out_scale <= pwdata[SCALE_W-1:0];
        OFS_AOUT_SOURCE: analog_out_source <= pwdata[3:0];
        default: begin
          if (paddr >= OFS_PRESET0 && paddr <= OFS_PRESET7 && paddr[1:0] == 2'b00) begin
            preset_freq[3'(paddr[4:2] - OFS_PRESET0[4:2])] <= pwdata[FREQ_W-1:0];
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      internal_freq_value <= RST_INT_FREQ;
    end else if (apb_write && paddr == OFS_INT_FREQ) begin
      internal_freq_value <= pwdata[FREQ_W-1:0];
    end else if (enter_edge) begin
      internal_freq_value <= live_freq;
    end
  end

  always_comb begin
    rd_mux = 32'h0;
    unique case (paddr)
      OFS_SOURCE:      rd_mux = {28'h0, speed_ref_source};
      OFS_DIN_FUNC:    rd_mux = {3'h0, din_func[3], 3'h0, din_func[2],
                                 3'h0, din_func[1], 3'h0, din_func[0]};
      OFS_MAX_FREQ:    rd_mux = {20'h0, max_freq_limit};
      OFS_ACCEL1:      rd_mux = {19'h0, accel_time_set1};
      OFS_DECEL1:      rd_mux = {19'h0, decel_time_set1};
      OFS_ACCEL2:      rd_mux = {19'h0, accel_time_set2};
      OFS_DECEL2:      rd_mux = {19'h0, decel_time_set2};
      OFS_INT_FREQ:    rd_mux = {20'h0, internal_freq_value};
      OFS_JOG_FREQ:    rd_mux = {20'h0, jog_freq_value};
      OFS_JOG_RAMP:    rd_mux = {19'h0, jog_ramp_time};
      OFS_AOUT_SCALE:  rd_mux = {22'h0, analog_out_scale};
      OFS_AOUT_SOURCE: rd_mux = {28'h0, analog_out_source};
      OFS_STATUS:      rd_mux = {4'h0, out_freq, 4'h0, freq_cmd};
      OFS_AOUT:        rd_mux = {16'h0, analog_out};
      OFS_LIVE_FREQ:   rd_mux = {20'h0, live_freq};
      default: begin
        if (paddr >= OFS_PRESET0 && paddr <= OFS_PRESET7) begin
          rd_mux = {20'h0, preset_freq[3'(paddr[4:2] - OFS_PRESET0[4:2])]};
        end
      end
    endcase
  end

  // pready rises one cycle into the access phase and drops after completion
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else if (apb_access && !pready) begin
      pready  <= 1'b1;
      pslverr <= ~addr_ok;
      prdata  <= (addr_ok && !pwrite) ? rd_mux : 32'h0;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end
  end

endmodule : srs_top

// [verification/srs_panel_model.sv]
`timescale 1ns/10ps
module srs_panel_model (
  input  wire logic       ref_clk,
  output logic      [3:0] digital_in,
  output logic            key_up,
  output logic            key_down,
  output logic            key_enter,
  output logic            key_esc,
  output logic            program_mode,
  output logic            jog_cmd
);
  initial begin
    digital_in = 4'h0;
    {key_up, key_down, key_enter, key_esc, program_mode, jog_cmd} = 6'h00;
  end
  task automatic set_in(input logic [3:0] din, input logic prog, input logic jog);
    @(posedge ref_clk);
    digital_in   <= din;
    program_mode <= prog;
    jog_cmd      <= jog;
  endtask : set_in
  // held 4 cycles so the synchroniser and edge detect see each press once
  task automatic press(input logic [3:0] key);
    @(posedge ref_clk);
    {key_esc, key_enter, key_down, key_up} <= key;
    repeat (4) @(posedge ref_clk);
    {key_esc, key_enter, key_down, key_up} <= 4'h0;
    repeat (4) @(posedge ref_clk);
  endtask : press
endmodule : srs_panel_model

// [verification/srs_checker.sv]
`timescale 1ns/10ps
module srs_checker
  import srs_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = 20
) (
  input wire logic                       ref_clk,
  input wire logic                       sys_rst,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pready,
  input wire logic                       pslverr,
  input wire logic [31:0]                prdata,
  input wire logic [srs_pkg::AOUT_W-1:0] analog_raw,
  input wire logic [srs_pkg::AOUT_W-1:0] analog_out,
  input wire logic [srs_pkg::FREQ_W-1:0] freq_cmd,
  input wire logic [srs_pkg::FREQ_W-1:0] out_freq,
  input wire logic                       nv_store
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence setup_s; psel && !penable; endsequence
  sequence access_s; psel && penable; endsequence
  chk_apb_one_wait: assert property (setup_s ##1 access_s |=> pready ##1 !pready)
    else $error("pready not after exactly one wait state");
  chk_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside a transfer");
  chk_store_pulse: assert property (nv_store |=> !nv_store)
    else $error("nv_store wider than one cycle");
  chk_step_spacing: assert property ($changed(out_freq) |=> $stable(out_freq))
    else $error("out_freq moved on consecutive cycles");
  chk_cmd_range: assert property (freq_cmd <= INT_FREQ_MAX)
    else $error("freq_cmd above frequency range");
  chk_aout_zero: assert property (analog_raw == 16'h0000 |=> analog_out == 16'h0000)
    else $error("analog_out not zero for zero source");
  // settled ramp must not drift off its target
  chk_ramp_hold: assert property ((out_freq == freq_cmd && $stable(freq_cmd)) [*3] |=> $stable(out_freq))
    else $error("out_freq left a settled target");
endmodule : srs_checker
bind srs_top srs_checker #(.TICK_CYCLES(TICK_CYCLES)) srs_checker_inst (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .prdata(prdata), .analog_raw(analog_raw), .analog_out(analog_out),
  .freq_cmd(freq_cmd), .out_freq(out_freq), .nv_store(nv_store));

// [verification/tb.sv]
`timescale 1ns/10ps
module tb;
  import srs_pkg::*;
  localparam int unsigned TK = 20;
  logic        ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr, err, nv_store;
  logic        key_up, key_down, key_enter, key_esc, program_mode, jog_cmd;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_data;
  logic [3:0]  digital_in;
  logic [11:0] ext_freq_ref, freq_cmd, out_freq;
  logic [15:0] analog_raw, analog_out;
  int          fails, compares, stores;
  logic [7:0]  rofs [8] = '{8'h00, 8'h08, 8'h14, 8'h18, 8'h20, 8'h24, 8'h28, 8'h34};
  logic [31:0] rval [8] = '{32'h0, 32'h258, 32'hC8, 32'hC8, 32'h64, 32'h64, 32'h64, 32'h32};
  srs_top #(.TICK_CYCLES(TK)) srs_top_inst (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .digital_in(digital_in), .key_up(key_up), .key_down(key_down), .key_enter(key_enter),
    .key_esc(key_esc), .program_mode(program_mode), .jog_cmd(jog_cmd),
    .ext_freq_ref(ext_freq_ref), .analog_raw(analog_raw), .freq_cmd(freq_cmd),
    .out_freq(out_freq), .analog_out(analog_out), .nv_store(nv_store));
  srs_panel_model srs_panel_model_inst (
    .ref_clk(ref_clk), .digital_in(digital_in), .key_up(key_up), .key_down(key_down),
    .key_enter(key_enter), .key_esc(key_esc), .program_mode(program_mode), .jog_cmd(jog_cmd));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (nv_store === 1'b1) stores++;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1 && ++n < 40);
    rd_data = prdata;
    err = pslverr;
    check(32'(pready), 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd_data, e);
  endtask : rd
  task automatic want(input logic [11:0] e);
    int n;
    n = 0;
    while (freq_cmd !== e && n < 300) begin
      @(posedge ref_clk);
      n++;
    end
    check(32'(freq_cmd), 32'(e));
  endtask : want
  // slack: a new step lands up to 3 ticks late, and the old step may be 3x the new
  task automatic ramp(input logic [11:0] t, input int stp);
    int c;
    int e;
    logic [11:0] s;
    s = out_freq;
    c = 0;
    while (out_freq !== t && c < 50000) begin
      @(posedge ref_clk);
      c++;
    end
    e = (((s > t) ? int'(s - t) : int'(t - s)) + stp - 1) / stp;
    check(32'(out_freq), 32'(t));
    check(32'(c / TK >= e - 7 && c / TK <= e + 3), 32'h1);
  endtask : ramp
  task automatic complete_run;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run
  initial begin
    repeat (100000) @(posedge ref_clk);
    fails++;
    $display("ERROR at %0t: watchdog expired", $time);
    complete_run();
  end
  initial begin
    {sys_rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    {ext_freq_ref, analog_raw, fails, compares, stores} = '0;
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 8; i++) rd(rofs[i], rval[i]);
    apb(1'b0, 8'h5C, 32'h0);
    check(32'(err), 32'h1);
    wr(OFS_ACCEL1, 32'h1);
    wr(OFS_DECEL1, 32'h1);
    wr(OFS_ACCEL2, 32'h2);
    wr(OFS_DECEL2, 32'h2);
    wr(OFS_JOG_RAMP, 32'h3);
    wr(OFS_SOURCE, 32'h1);
    want(12'h258);
    ramp(12'h258, 6);
    wr(OFS_DIN_FUNC, 32'h0404);
    srs_panel_model_inst.set_in(4'h1, 1'b0, 1'b0);
    want(12'h032);
    ramp(12'h032, 6);
    srs_panel_model_inst.set_in(4'h3, 1'b0, 1'b0);
    want(12'h0C8);
    ramp(12'h0C8, 3);
    srs_panel_model_inst.set_in(4'h2, 1'b0, 1'b0);
    ramp(12'h064, 3);
    wr(OFS_DIN_FUNC, 32'h05000404);
    srs_panel_model_inst.set_in(4'h9, 1'b0, 1'b0);
    ramp(12'h032, 3);
    srs_panel_model_inst.set_in(4'h0, 1'b0, 1'b0);
    wr(OFS_SOURCE, 32'h4);
    want(12'h000);
    wr(OFS_PRESET0, 32'h7B);
    want(12'h07B);
    wr(OFS_SOURCE, 32'h0);
    ext_freq_ref <= 12'h04D;
    want(12'h04D);
    srs_panel_model_inst.set_in(4'h0, 1'b0, 1'b1);
    want(12'h064);
    ramp(12'h064, 2);
    wr(OFS_JOG_FREQ, 32'h2BC);
    want(12'h258);
    srs_panel_model_inst.set_in(4'h0, 1'b1, 1'b0);
    wr(OFS_SOURCE, 32'h1);
    srs_panel_model_inst.press(4'h2);
    want(12'h257);
    srs_panel_model_inst.press(4'h4);
    check(32'(stores), 32'h1);
    rd(OFS_INT_FREQ, 32'h257);
    srs_panel_model_inst.press(4'h2);
    want(12'h256);
    srs_panel_model_inst.press(4'h8);
    want(12'h257);
    wr(OFS_SOURCE, 32'h0);
    wr(OFS_DIN_FUNC, 32'h11);
    srs_panel_model_inst.set_in(4'h0, 1'b0, 1'b0);
    want(12'h257);
    srs_panel_model_inst.set_in(4'h1, 1'b0, 1'b0);
    repeat (10 * TK) @(posedge ref_clk);
    check(32'(freq_cmd < 12'h257), 32'h1);
    wr(OFS_AOUT_SCALE, 32'h32);
    analog_raw <= 16'h8000;
    repeat (3) @(posedge ref_clk);
    check(32'(analog_out), 32'h4000);
    wr(OFS_AOUT_SCALE, 32'h320);
    rd(OFS_AOUT, 32'hFFFF);
    complete_run();
  end
endmodule : tb
